// ---- down_timer.sv ----
// Standard 16-bit down timer with 8-bit prescaler behind an 8-bit register port.
// Assumes one 200 MHz clock; timer_input_pin and ext_irq_pin are asynchronous pins.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Run bit starts counting, clearing halts it
// - Restart resumes, or loads constant written while stopped
// - Running: constant at end, prescaler immediately
// - Counter and prescaler bytes reset to all ones
// - Single mode stops, reloads, clears run bit
// - Continuous mode reloads and restarts each end
// - Mode select writable anytime, with run together
// - Input disabled: count internal clock divided four
// - Event mode counts input falling edges
// - Gated mode counts while pin is high
// - Triggerable mode starts on run plus falling edge
// - Retriggerable edge while running reloads constants
// - Time base variant counts oscillator clock
// - Output mode zero holds pin high
// - Square wave toggles pin at end
// - PWM copies lower mode bit at end
// - Select bit picks timer or external interrupt
// - End of count is underflow at zero
// - Count bytes write constant, read live value
// - Prescaler divides by value plus one
module down_timer #(
    parameter bit TIME_BASE_VARIANT = 1'b0
) (
    input  wire logic       clock_in,
    input  wire logic       srst_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    input  wire logic       reg_read_in,
    output logic      [7:0] reg_rdata_out,
    input  wire logic       timer_input_pin_in,
    input  wire logic       oscillator_derived_clock_in,
    input  wire logic       ext_irq_pin_in,
    output logic            timer_output_pin_out,
    output logic            irq_channel_out
);
    import down_timer_pkg::*;

    // Software-visible registers and timer state
    logic [7:0]  const_high_q;
    logic [7:0]  const_low_q;
    logic [7:0]  prescale_q;
    logic [7:0]  control_q;
    logic [15:0] count_q;
    logic [7:0]  pre_count_q;
    logic [1:0]  tick_div_q;
    logic        pending_load_q;
    logic        armed_q;
    logic        out_q;
    logic        irq_q;
    logic [7:0]  rdata_q;
    logic [2:0]  pin_sync_q;
    logic [1:0]  irq_sync_q;
    logic [2:0]  osc_sync_q;

    // Both sources are synchronised first and selected afterwards, so the
    // variant choice never sits in front of a first flip-flop
    wire [2:0] src_sync  = TIME_BASE_VARIANT ? osc_sync_q : pin_sync_q;
    wire       pin_level = src_sync[1];
    wire       pin_fall  = src_sync[2] & ~src_sync[1];

    wire       run_bit            = control_q[RUN_BIT_POS];
    wire       single_mode        = control_q[SINGLE_POS];
    wire       input_section_enable = control_q[IN_ENABLE_POS];
    wire       irq_source_select  = control_q[IRQ_SEL_POS];
    wire       output_mode_upper  = control_q[OUT_MODE_HI_POS];
    wire       output_mode_lower  = control_q[OUT_MODE_LO_POS];
    wire [1:0] in_mode_bits       = {control_q[IN_MODE_HI_POS], control_q[IN_MODE_LO_POS]};
    wire in_mode_e in_mode        = in_mode_e'(in_mode_bits);

    // Address match shared by the write strobes
    function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] target);
        reg_hit = (addr == target);
    endfunction

    wire wr_high = reg_write_in && reg_hit(reg_addr_in, COUNT_HIGH_ADDR);
    wire wr_low  = reg_write_in && reg_hit(reg_addr_in, COUNT_LOW_ADDR);
    wire wr_pre  = reg_write_in && reg_hit(reg_addr_in, PRESCALE_ADDR);
    wire wr_ctl  = reg_write_in && reg_hit(reg_addr_in, CONTROL_ADDR);

    // Free-running divide-by-four; it does not restart with the run bit
    wire internal_tick = (tick_div_q == TICK_LAST);

    // Timer clock source by input mode
    logic src_tick;
    always_comb begin
        if (!input_section_enable) begin
            src_tick = internal_tick;
        end else begin
            case (in_mode)
                IN_EVENT:     src_tick = pin_fall;
                IN_GATED:     src_tick = internal_tick & pin_level;
                IN_TRIGGER:   src_tick = internal_tick & armed_q;
                IN_RETRIGGER: src_tick = internal_tick;
                default:      src_tick = internal_tick;
            endcase
        end
    end

    // A retrigger wins over a tick in the same cycle, so the reload is not decremented
    wire retrigger = input_section_enable && (in_mode == IN_RETRIGGER)
                     && run_bit && pin_fall;
    // No counting in the cycle that loads a pending constant
    wire counting     = run_bit && !pending_load_q;
    wire pre_terminal = (pre_count_q == 8'h00);
    wire count_tick   = counting && src_tick && pre_terminal && !retrigger;
    wire end_of_count = count_tick && (count_q == 16'h0000);
    wire [15:0] constant_val = {const_high_q, const_low_q};
    // A restart after a stopped write, or a retrigger edge, loads both constants
    wire load_constants = (run_bit && pending_load_q) || retrigger;

    // Control register: a software write wins over the single-mode auto stop
    logic [7:0] control_d;
    always_comb begin
        control_d = control_q;
        if (wr_ctl) begin
            control_d = reg_wdata_in;
        end else if (end_of_count && single_mode) begin
            control_d[RUN_BIT_POS] = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            control_q <= CONTROL_RESET;
        end else begin
            control_q <= control_d;
        end
    end

    // Constant and prescaler registers
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            const_high_q <= COUNT_BYTE_RESET;
            const_low_q  <= COUNT_BYTE_RESET;
            prescale_q   <= PRESCALE_RESET;
        end else begin
            if (wr_high) begin
                const_high_q <= reg_wdata_in;
            end
            if (wr_low) begin
                const_low_q <= reg_wdata_in;
            end
            if (wr_pre) begin
                prescale_q <= reg_wdata_in;
            end
        end
    end

    // A constant written while stopped is loaded when the run bit is next set
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pending_load_q <= 1'b0;
        end else if (run_bit && pending_load_q) begin
            pending_load_q <= 1'b0;
        end else if ((wr_high || wr_low) && !run_bit) begin
            pending_load_q <= 1'b1;
        end
    end

    // Triggerable mode waits for a falling edge after the run bit is set
    always_ff @(posedge clock_in) begin
        if (srst_in || !run_bit) begin
            armed_q <= 1'b0;
        end else if (pin_fall) begin
            armed_q <= 1'b1;
        end
    end

    // Internal divide-by-four tick
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            tick_div_q <= 2'h0;
        end else begin
            tick_div_q <= tick_div_q + 2'h1;
        end
    end

    // Prescaler: divides the selected tick by value plus one
    logic [7:0] pre_count_d;
    always_comb begin
        if (wr_pre) begin
            pre_count_d = reg_wdata_in;
        end else if (load_constants) begin
            pre_count_d = prescale_q;
        end else if (counting && src_tick) begin
            pre_count_d = pre_terminal ? prescale_q : pre_count_q - 8'h01;
        end else begin
            pre_count_d = pre_count_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pre_count_q <= PRESCALE_RESET;
        end else begin
            pre_count_q <= pre_count_d;
        end
    end

    // Down counter: a load or an underflow reload takes priority over a decrement
    logic [15:0] count_d;
    always_comb begin
        if (load_constants) begin
            count_d = constant_val;
        end else if (end_of_count) begin
            count_d = constant_val;
        end else if (count_tick) begin
            count_d = count_q - 16'h0001;
        end else begin
            count_d = count_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            count_q <= {COUNT_BYTE_RESET, COUNT_BYTE_RESET};
        end else begin
            count_q <= count_d;
        end
    end

    // Output pin: held high while disabled so the pin is free for other uses
    logic out_d;
    always_comb begin
        if (!output_mode_upper && !output_mode_lower) begin
            out_d = 1'b1;
        end else if (end_of_count) begin
            out_d = output_mode_upper ? output_mode_lower : ~out_q;
        end else begin
            out_d = out_q;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            out_q <= 1'b1;
        end else begin
            out_q <= out_d;
        end
    end

    // Interrupt channel: end-of-count pulse or external pin
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_source_select ? irq_sync_q[1] : end_of_count;
        end
    end

    // Pin synchronisers
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            pin_sync_q <= 3'h7;
            irq_sync_q <= 2'h0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], timer_input_pin_in};
            irq_sync_q <= {irq_sync_q[0], ext_irq_pin_in};
        end
    end

    // Oscillator line synchroniser, used only by the time-base variant
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            osc_sync_q <= 3'h7;
        end else begin
            osc_sync_q <= {osc_sync_q[1:0], oscillator_derived_clock_in};
        end
    end

    // Read data: live count, programmed prescaler, control
    // Unmapped addresses read as zero
    logic [7:0] rdata_d;
    always_comb begin
        case (reg_addr_in)
            COUNT_HIGH_ADDR: rdata_d = count_q[15:8];
            COUNT_LOW_ADDR:  rdata_d = count_q[7:0];
            PRESCALE_ADDR:   rdata_d = prescale_q;
            CONTROL_ADDR:    rdata_d = control_q;
            default:         rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            rdata_q <= 8'h00;
        end else if (reg_read_in) begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_out        = rdata_q;
    assign timer_output_pin_out = out_q;
    assign irq_channel_out      = irq_q;
endmodule
`default_nettype wire

// ---- down_timer_pkg.sv ----
// Package for the down timer: register offsets, control field layout, reset values.
// Assumes an 8-bit register-file port with byte addresses F0h..F3h.
package down_timer_pkg;
    localparam logic [7:0] COUNT_HIGH_ADDR = 8'hF0;
    localparam logic [7:0] COUNT_LOW_ADDR  = 8'hF1;
    localparam logic [7:0] PRESCALE_ADDR   = 8'hF2;
    localparam logic [7:0] CONTROL_ADDR    = 8'hF3;

    localparam logic [7:0] COUNT_BYTE_RESET = 8'hFF;
    localparam logic [7:0] PRESCALE_RESET   = 8'hFF;
    localparam logic [7:0] CONTROL_RESET    = 8'h14;

    localparam int RUN_BIT_POS     = 7;
    localparam int SINGLE_POS      = 6;
    localparam int IN_MODE_HI_POS  = 5;
    localparam int IN_MODE_LO_POS  = 4;
    localparam int IN_ENABLE_POS   = 3;
    localparam int IRQ_SEL_POS     = 2;
    localparam int OUT_MODE_HI_POS = 1;
    localparam int OUT_MODE_LO_POS = 0;

    // Internal clock divided by this many cycles gives the timer tick
    localparam int          TICK_DIVIDE = 4;
    localparam logic [1:0]  TICK_LAST   = 2'(TICK_DIVIDE - 1);

    typedef enum logic [1:0] {
        IN_EVENT,
        IN_GATED,
        IN_TRIGGER,
        IN_RETRIGGER
    } in_mode_e;
endpackage

// ---- down_timer_checker.sv ----
// Port checker for the down timer.
// Assumes it is bound onto down_timer.
`timescale 1ns/1ps
`default_nettype none
module down_timer_checker (
    input wire logic       clock_in,
    input wire logic       srst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_write_in,
    input wire logic       reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic       timer_output_pin_out,
    input wire logic       irq_channel_out
);
    import down_timer_pkg::*;
    logic [7:0] ctrl_q;
    logic       ctrl_wr;
    assign ctrl_wr = reg_write_in && reg_addr_in == CONTROL_ADDR;
    // Shadow of the software-written control bits
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            ctrl_q <= CONTROL_RESET;
        end else if (ctrl_wr) begin
            ctrl_q <= reg_wdata_in;
        end
    end
    default clocking @(posedge clock_in); endclocking
    default disable iff (srst_in);
    reset_outputs_a: assert property ($fell(srst_in) |-> reg_rdata_out == 8'h00
        && timer_output_pin_out && !irq_channel_out) else $error("bad outputs after reset");
    read_hold_a: assert property (!reg_read_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    prescale_readback_a: assert property (reg_write_in && reg_addr_in == PRESCALE_ADDR
        ##2 reg_read_in && reg_addr_in == PRESCALE_ADDR
        |=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("prescaler readback wrong");
    irq_pulse_a: assert property (!ctrl_q[2] && irq_channel_out
        |=> ctrl_q[2] || !irq_channel_out) else $error("interrupt pulse too long");
    out_disabled_a: assert property (ctrl_q[1:0] == 2'b00
        && $past(ctrl_q[1:0]) == 2'b00 |-> timer_output_pin_out) else $error("pin not high");
    square_toggle_a: assert property (ctrl_q[2:0] == 3'b001
        && $past(ctrl_q[2:0]) == 3'b001 && irq_channel_out
        |-> timer_output_pin_out != $past(timer_output_pin_out)) else $error("no toggle");
    square_hold_a: assert property (ctrl_q[2:0] == 3'b001
        && $past(ctrl_q[2:0]) == 3'b001 && !irq_channel_out
        |-> $stable(timer_output_pin_out)) else $error("pin moved between ends");
    pwm_copy_a: assert property (ctrl_q[2:1] == 2'b01
        && $past(ctrl_q[2:1]) == 2'b01 && irq_channel_out
        |-> timer_output_pin_out == $past(ctrl_q[0])) else $error("pwm level wrong");
endmodule
bind down_timer down_timer_checker down_timer_checker_i (.clock_in, .srst_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .timer_output_pin_out,
    .irq_channel_out);
`default_nettype wire

// ---- edge_source.sv ----
// Far-side model: drives the timer input pin with falling-edge events.
// Assumes one clock shared with the bench; fire_in is a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
module edge_source (
    input  wire logic clock_in,
    input  wire logic srst_in,
    input  wire logic fire_in,
    input  wire logic level_in,
    output logic      pin_out,
    output logic      busy_out
);
    logic [3:0] phase_q;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            phase_q <= 4'h0;
        end else if (phase_q != 4'h0) begin
            phase_q <= phase_q - 4'h1;
        end else if (fire_in) begin
            phase_q <= 4'h8;
        end
    end
    // Low four cycles then high four, so falling edges stay at least nine clocks apart
    assign busy_out = phase_q != 4'h0;
    assign pin_out  = busy_out ? (phase_q < 4'h5) : level_in;
endmodule
`default_nettype wire

// ---- down_timer_tb.sv ----
// Self-checking bench for the down timer.
// Assumes the package, the design, the checker and edge_source are compiled first.
`timescale 1ns/1ps
`default_nettype none
module down_timer_tb;
    import down_timer_pkg::*;
    typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } row_s;
    row_s rows [5] = '{'{8'hF2, 8'h00, 8'h00}, '{8'hF2, 8'h01, 8'h01}, '{8'hF2, 8'hFF, 8'hFF},
        '{8'hF3, 8'h03, 8'h03}, '{8'hF4, 8'h55, 8'h00}};
    logic clock_in, srst_in, wr, rd, fire, level, ext, pin_in, busy, pin_out, irq;
    logic [7:0] addr, wdata, rdata, rdata_osc, v, w;
    int tests_run = 0;
    int miscompares = 0;
    down_timer down_timer_i (.clock_in, .srst_in, .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata), .timer_input_pin_in(pin_in),
        .oscillator_derived_clock_in(1'b0), .ext_irq_pin_in(ext),
        .timer_output_pin_out(pin_out), .irq_channel_out(irq));
    // Time-base variant: counts the oscillator line, its own input pin held idle
    down_timer #(.TIME_BASE_VARIANT(1'b1)) down_timer_osc_i (.clock_in, .srst_in,
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd),
        .reg_rdata_out(rdata_osc), .timer_input_pin_in(1'b1),
        .oscillator_derived_clock_in(pin_in), .ext_irq_pin_in(ext),
        .timer_output_pin_out(), .irq_channel_out());
    edge_source edge_source_i (.clock_in, .srst_in, .fire_in(fire), .level_in(level),
        .pin_out(pin_in), .busy_out(busy));
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in) {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clock_in) wr = 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] q);
        @(negedge clock_in) {addr, rd} = {a, 1'b1};
        @(negedge clock_in) rd = 1'b0;
        q = rdata;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        rreg(a, q);
        chk(n, {8'h00, e}, {8'h00, q});
    endtask
    task automatic period(input logic [15:0] e);
        logic [15:0] n;
        logic p;
        for (int k = 0; k < 2; k++) begin
            n = 16'h0000;
            p = pin_out;
            while (pin_out === p && n < 16'h03E8) begin
                @(negedge clock_in);
                n++;
            end
        end
        chk("toggle period", e, n);
    endtask
    task automatic fire_edge();
        @(negedge clock_in) fire = 1'b1;
        @(negedge clock_in) fire = 1'b0;
        repeat (9) @(negedge clock_in);
    endtask
    task automatic test_done();
        $display("comparisons %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        {addr, wdata, wr, rd, fire, ext} = '0;
        {level, srst_in} = 2'b11;
        repeat (4) @(negedge clock_in);
        srst_in = 1'b0;
        rchk("high byte", COUNT_HIGH_ADDR, COUNT_BYTE_RESET);
        rchk("low byte", COUNT_LOW_ADDR, COUNT_BYTE_RESET);
        rchk("prescaler", PRESCALE_ADDR, PRESCALE_RESET);
        rchk("control", CONTROL_ADDR, CONTROL_RESET);
        foreach (rows[i]) begin
            wreg(rows[i].a, rows[i].d);
            rchk("register row", rows[i].a, rows[i].e);
        end
        wreg(8'hF2, 8'h00);
        wreg(8'hF1, 8'h02);
        wreg(8'hF0, 8'h00);
        wreg(8'hF3, 8'h81);
        period(16'd12);
        wreg(8'hF2, 8'h01);
        period(16'd24);
        wreg(8'hF3, 8'h82);
        repeat (30) @(negedge clock_in);
        chk("pwm low", 16'h0, {15'h0, pin_out});
        wreg(8'hF3, 8'h83);
        repeat (30) @(negedge clock_in);
        chk("pwm high", 16'h1, {15'h0, pin_out});
        wreg(8'hF2, 8'h00);
        wreg(8'hF3, 8'hC1);
        repeat (40) @(negedge clock_in);
        rchk("single stop", CONTROL_ADDR, 8'h41);
        rchk("single reload", COUNT_LOW_ADDR, 8'h02);
        wreg(8'hF1, 8'hFF);
        wreg(8'hF3, 8'h80);
        repeat (20) @(negedge clock_in);
        wreg(8'hF3, 8'h00);
        rreg(COUNT_LOW_ADDR, v);
        chk("counting moved", 16'h1, {15'h0, v < 8'hFF});
        repeat (20) @(negedge clock_in);
        rchk("halted", COUNT_LOW_ADDR, v);
        wreg(8'hF3, 8'h80);
        repeat (8) @(negedge clock_in);
        wreg(8'hF3, 8'h00);
        rreg(COUNT_LOW_ADDR, w);
        chk("resumed", 16'h1, {15'h0, w < v && w + 8'h04 >= v});
        wreg(8'hF1, 8'h10);
        wreg(8'hF0, 8'h00);
        wreg(8'hF3, 8'h88);
        repeat (3) fire_edge();
        rchk("events", COUNT_LOW_ADDR, 8'h0D);
        chk("time base", 16'h000D, {8'h00, rdata_osc});
        level = 1'b0;
        wreg(8'hF3, 8'h98);
        repeat (20) @(negedge clock_in);
        rchk("gate closed", COUNT_LOW_ADDR, 8'h0D);
        level = 1'b1;
        repeat (20) @(negedge clock_in);
        rreg(COUNT_LOW_ADDR, w);
        chk("gate open", 16'h1, {15'h0, w < 8'h0D});
        wreg(8'hF3, 8'h00);
        wreg(8'hF1, 8'h40);
        wreg(8'hF3, 8'hA8);
        repeat (20) @(negedge clock_in);
        rchk("wait trigger", COUNT_LOW_ADDR, 8'h40);
        fire_edge();
        rreg(COUNT_LOW_ADDR, w);
        chk("triggered", 16'h1, {15'h0, w < 8'h40});
        wreg(8'hF3, 8'hB8);
        repeat (40) @(negedge clock_in);
        fire_edge();
        rreg(COUNT_LOW_ADDR, w);
        chk("retriggered", 16'h1, {15'h0, w >= 8'h3E});
        wreg(8'hF3, 8'h38);
        rreg(COUNT_LOW_ADDR, v);
        fire_edge();
        rchk("stopped edge", COUNT_LOW_ADDR, v);
        wreg(8'hF3, 8'h04);
        ext = 1'b1;
        repeat (6) @(negedge clock_in);
        chk("ext irq high", 16'h1, {15'h0, irq});
        ext = 1'b0;
        repeat (6) @(negedge clock_in);
        chk("ext irq low", 16'h0, {15'h0, irq});
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clock_in);
        miscompares++;
        test_done();
    end
endmodule
`default_nettype wire
